//--- hdl/hub_strap_led_port_power_pins.sv
/*
 * strap sampling, indicator led drive, vbus connect and port power
 * enables of a seven-port hub, with an axi4-lite register slave.
 * assumes all pin inputs are synchronous to clk; shared led pins
 * are two-way and resolved outside from out/oe.
 */
`timescale 1ns/10ps
module hub_strap_led_port_power_pins (
   input  wire logic                      clk,
   input  wire logic                      rst,
   input  wire logic                      upstream_vbus_sense,
   output logic                           upstreamPullupEnable,
   input  wire logic                      port_power_polarity_strap,
   output logic [hub_pins_pkg::NPORTS-1:0] port_power_enable,
   output logic [hub_pins_pkg::NPORTS-1:0] green_led_out,
   output logic [3:0]                     greenLedOe,
   input  wire logic [3:0]                greenLedIn,
   output logic [2:0]                     amber_led_out,
   input  wire logic                      useDefaultConfig,
   input  wire logic [hub_pins_pkg::NPORTS-1:0] portPowerReq,
   input  wire logic [hub_pins_pkg::NPORTS-1:0] greenLedReq,
   input  wire logic [2:0]                amberLedReq,
   output logic [hub_pins_pkg::NPORTS-1:0] portDisabled,
   output logic [hub_pins_pkg::NPORTS-1:0] portFixed,
   input  wire logic [hub_pins_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                      s_axi_awvalid,
   output logic                           s_axi_awready,
   input  wire logic [31:0]               s_axi_wdata,
   input  wire logic [3:0]                s_axi_wstrb,
   input  wire logic                      s_axi_wvalid,
   output logic                           s_axi_wready,
   output logic [1:0]                     s_axi_bresp,
   output logic                           s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   input  wire logic [hub_pins_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic                      s_axi_arvalid,
   output logic                           s_axi_arready,
   output logic [31:0]                    s_axi_rdata,
   output logic [1:0]                     s_axi_rresp,
   output logic                           s_axi_rvalid,
   input  wire logic                      s_axi_rready
);
   import hub_pins_pkg::*;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   // ****************************************************************
   // functions
   // ****************************************************************
   function automatic port_mask_t disMask(input logic [1:0] s);
      case (s)
         STRAP_NONE:  disMask = DIS_MASK_0;
         STRAP_ONE:   disMask = DIS_MASK_1;
         STRAP_TWO:   disMask = DIS_MASK_2;
         STRAP_THREE: disMask = DIS_MASK_3;
         default:     disMask = DIS_MASK_0;
      endcase
   endfunction

   function automatic port_mask_t fixMask(input logic [1:0] s);
      case (s)
         STRAP_NONE:  fixMask = FIX_MASK_0;
         STRAP_ONE:   fixMask = FIX_MASK_1;
         STRAP_TWO:   fixMask = FIX_MASK_2;
         STRAP_THREE: fixMask = FIX_MASK_3;
         default:     fixMask = FIX_MASK_0;
      endcase
   endfunction

   function automatic logic regHit(input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] r);
      regHit = (a == r);
   endfunction

   // ****************************************************************
   // strap capture
   // ****************************************************************
   strap_state_e strapState;
   logic [1:0]   disStrap;
   logic [1:0]   fixStrap;
   logic         polarityLatched;
   logic         defaultMode;
   logic         ledEnable;
   port_mask_t   powerOn;
   logic         polarityNow;
   logic         stHold;

   assign stHold = (strapState == ST_HOLD);

   // shared pins are released during reset so the board straps read
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         strapState      <= ST_SAMPLE;
         disStrap        <= STRAP_NONE;
         fixStrap        <= STRAP_NONE;
         polarityLatched <= 1'h0;
         defaultMode     <= 1'h0;
      end else begin
         case (strapState)
            ST_SAMPLE: begin
               polarityLatched <= port_power_polarity_strap;
               defaultMode     <= useDefaultConfig;
               if (useDefaultConfig) begin
                  disStrap <= greenLedIn[3:2];
                  fixStrap <= greenLedIn[1:0];
               end
               strapState <= ST_HOLD;
            end
            ST_HOLD: strapState <= ST_HOLD;
            default: strapState <= ST_SAMPLE;
         endcase
      end
   end

   // ****************************************************************
   // port status and power
   // ****************************************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         portDisabled <= DIS_MASK_0;
         portFixed    <= FIX_MASK_0;
      end else begin
         portDisabled <= disMask(disStrap);
         portFixed    <= fixMask(fixStrap);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         powerOn <= DIS_MASK_0;
      end else if (stHold) begin
         // decode straps directly so a disabled port never sees one powered cycle
         powerOn <= portPowerReq & ~disMask(disStrap);
      end
   end

   // the pin level, not a flop, sets polarity until the latch is taken
   assign polarityNow = stHold ? polarityLatched : port_power_polarity_strap;
   assign port_power_enable = polarityNow ? powerOn : ~powerOn;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         upstreamPullupEnable <= 1'h0;
      end else begin
         upstreamPullupEnable <= upstream_vbus_sense;
      end
   end

   // ****************************************************************
   // indicator leds
   // ****************************************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         green_led_out[6:4] <= 3'h7;
         amber_led_out      <= 3'h7;
      end else begin
         green_led_out[6:4] <= ~greenLedReq[6:4];
         amber_led_out      <= ~amberLedReq;
      end
   end

   logic [3:0] sharedPol;
   assign sharedPol = {disStrap, fixStrap};

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_shared
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               green_led_out[g] <= 1'h1;
               greenLedOe[g]    <= 1'h0;
            end else if (!stHold) begin
               green_led_out[g] <= 1'h1;
               greenLedOe[g]    <= 1'h0;
            end else if (defaultMode) begin
               // strap bit 1 means active low, 0 active high
               green_led_out[g] <= sharedPol[g] ? ~greenLedReq[g]
                                                : greenLedReq[g];
               greenLedOe[g]    <= 1'h1;
            end else begin
               green_led_out[g] <= ~greenLedReq[g];
               greenLedOe[g]    <= ledEnable;
            end
         end
      end
   endgenerate

   // ****************************************************************
   // axi4-lite write channel
   // ****************************************************************
   logic awGot;
   logic wGot;
   logic [ADDR_W-1:0] awAddr;
   logic [31:0] wData;
   logic [3:0]  wStrb;
   logic next_awGot;
   logic next_wGot;
   logic next_bvalid;
   logic doWrite;

   // address of the write being completed this cycle
   function automatic logic [ADDR_W-1:0] wAddrMux();
      wAddrMux = awGot ? awAddr : s_axi_awaddr;
   endfunction

   always_comb begin
      next_awGot  = awGot | (s_axi_awvalid & s_axi_awready);
      next_wGot   = wGot | (s_axi_wvalid & s_axi_wready);
      doWrite     = next_awGot & next_wGot & ~s_axi_bvalid;
      next_bvalid = doWrite | (s_axi_bvalid & ~s_axi_bready);
      if (doWrite) begin
         next_awGot = 1'h0;
         next_wGot  = 1'h0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         awGot         <= 1'h0;
         wGot          <= 1'h0;
         awAddr        <= REG_CTRL;
         wData         <= 32'h0;
         wStrb         <= 4'h0;
         s_axi_awready <= 1'h0;
         s_axi_wready  <= 1'h0;
         s_axi_bvalid  <= 1'h0;
         s_axi_bresp   <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awAddr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
         end
         awGot         <= next_awGot;
         wGot          <= next_wGot;
         s_axi_bvalid  <= next_bvalid;
         s_axi_awready <= ~next_awGot & ~next_bvalid;
         s_axi_wready  <= ~next_wGot & ~next_bvalid;
         if (doWrite) begin
            s_axi_bresp <= regHit(wAddrMux(), REG_CTRL) ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   logic       wLane0;
   logic       wBit0;
   assign wLane0 = wGot ? wStrb[0] : s_axi_wstrb[0];
   assign wBit0  = wGot ? wData[CTRL_LED_EN_BIT] : s_axi_wdata[CTRL_LED_EN_BIT];

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ledEnable <= CTRL_LED_EN_RESET;
      end else if (doWrite && wLane0 && regHit(wAddrMux(), REG_CTRL)) begin
         ledEnable <= wBit0;
      end
   end

   // ****************************************************************
   // axi4-lite read channel
   // ****************************************************************
   logic next_rvalid;
   logic rdTake;
   logic [31:0] rdWord;

   assign rdTake      = s_axi_arvalid & s_axi_arready;
   assign next_rvalid = rdTake | (s_axi_rvalid & ~s_axi_rready);

   always_comb begin
      rdWord = 32'h0;
      if (regHit(s_axi_araddr, REG_CTRL)) begin
         rdWord[CTRL_LED_EN_BIT] = ledEnable;
      end else if (regHit(s_axi_araddr, REG_STATUS)) begin
         rdWord[ST_DIS_LSB +: 2] = disStrap;
         rdWord[ST_FIX_LSB +: 2] = fixStrap;
         rdWord[ST_POL_BIT]      = polarityLatched;
         rdWord[ST_DEF_BIT]      = defaultMode;
         rdWord[ST_VBUS_BIT]     = upstreamPullupEnable;
         rdWord[ST_TAKEN_BIT]    = stHold;
      end else if (regHit(s_axi_araddr, REG_PORTS)) begin
         rdWord[PORTS_DIS_LSB +: NPORTS] = portDisabled;
         rdWord[PORTS_FIX_LSB +: NPORTS] = portFixed;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_axi_arready <= 1'h0;
         s_axi_rvalid  <= 1'h0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= RESP_OKAY;
      end else begin
         s_axi_arready <= ~next_rvalid;
         s_axi_rvalid  <= next_rvalid;
         if (rdTake) begin
            s_axi_rdata <= rdWord;
            s_axi_rresp <= (regHit(s_axi_araddr, REG_CTRL) ||
                            regHit(s_axi_araddr, REG_STATUS) ||
                            regHit(s_axi_araddr, REG_PORTS)) ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   // ****************************************************************
   // assertions
   // ****************************************************************
   a_pullup_vbus: assert property (
      !rst && upstream_vbus_sense != upstreamPullupEnable
      |=> upstreamPullupEnable == $past(upstream_vbus_sense))
      else $error("pull-up does not follow vbus");

   a_power_idle_level: assert property (
      stHold && $past(stHold) && $past(portPowerReq) == 7'h00
      |-> port_power_enable == {NPORTS{~polarityLatched}})
      else $error("idle port power not at inactive level");

   a_green_high_low: assert property (
      stHold |=> green_led_out[6:4] == ~$past(greenLedReq[6:4]))
      else $error("green leds 7..5 not active low");

   a_amber_low: assert property (
      stHold |=> amber_led_out == ~$past(amberLedReq))
      else $error("amber leds 7..5 not active low");

   a_cfg_led_low: assert property (
      stHold && !defaultMode && ledEnable
      |=> greenLedOe == SHARED_ALL && green_led_out[3:0] == ~$past(greenLedReq[3:0]))
      else $error("configured shared leds not active low");

   a_strap_taken: assert property (
      !rst && strapState == ST_SAMPLE && useDefaultConfig
      |=> disStrap == $past(greenLedIn[3:2]) && fixStrap == $past(greenLedIn[1:0]))
      else $error("straps not sampled at reset release");

   a_dis_decode: assert property (
      stHold && $past(stHold) && disStrap == STRAP_TWO |-> portDisabled == 7'h60)
      else $error("port disable decode wrong");

   a_fix_decode: assert property (
      stHold && $past(stHold) && fixStrap == STRAP_THREE |-> portFixed == 7'h07)
      else $error("fixed device decode wrong");

   a_strap_led_pol: assert property (
      stHold && defaultMode && !disStrap[1] |=> green_led_out[3] == $past(greenLedReq[3]))
      else $error("port 4 led polarity ignores strap");

   a_reset_power_off: assert property (
      strapState == ST_SAMPLE |-> port_power_enable == {NPORTS{~port_power_polarity_strap}})
      else $error("port power active before strap latched");

   a_straps_held: assert property (
      stHold && $past(stHold)
      |-> $stable(polarityLatched) && $stable(disStrap) && $stable(fixStrap))
      else $error("sampled straps changed after reset");

endmodule // hub_strap_led_port_power_pins

//--- hdl/hub_pins_pkg.sv
/*
 * constants for the hub strap / led / port power pin block.
 * assumes one 25 mhz clock and an axi4-lite register slave.
 */
package hub_pins_pkg;

   // ****************************************************************
   // sizes and types
   // ****************************************************************
   localparam int ADDR_W = 8;
   localparam int NPORTS = 7;
   typedef logic [NPORTS-1:0] port_mask_t;
   typedef enum logic {
      ST_SAMPLE = 1'b0,
      ST_HOLD   = 1'b1
   } strap_state_e;

   // ****************************************************************
   // register map
   // ****************************************************************
   localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
   localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
   localparam logic [ADDR_W-1:0] REG_PORTS  = 8'h08;
   localparam int CTRL_LED_EN_BIT = 0;
   localparam logic CTRL_LED_EN_RESET = 1'h0;
   localparam int ST_DIS_LSB   = 0;
   localparam int ST_FIX_LSB   = 2;
   localparam int ST_POL_BIT   = 4;
   localparam int ST_DEF_BIT   = 5;
   localparam int ST_VBUS_BIT  = 6;
   localparam int ST_TAKEN_BIT = 7;
   localparam int PORTS_DIS_LSB = 0;
   localparam int PORTS_FIX_LSB = 8;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ****************************************************************
   // strap decode
   // ****************************************************************
   localparam logic [1:0] STRAP_NONE  = 2'h0;
   localparam logic [1:0] STRAP_ONE   = 2'h1;
   localparam logic [1:0] STRAP_TWO   = 2'h2;
   localparam logic [1:0] STRAP_THREE = 2'h3;
   localparam port_mask_t DIS_MASK_0 = 7'h00;
   localparam port_mask_t DIS_MASK_1 = 7'h40;
   localparam port_mask_t DIS_MASK_2 = 7'h60;
   localparam port_mask_t DIS_MASK_3 = 7'h70;
   localparam port_mask_t FIX_MASK_0 = 7'h00;
   localparam port_mask_t FIX_MASK_1 = 7'h01;
   localparam port_mask_t FIX_MASK_2 = 7'h03;
   localparam port_mask_t FIX_MASK_3 = 7'h07;
   localparam logic [3:0] SHARED_ALL = 4'hf;

endpackage

//--- tb/hub_board_model.sv
/*
 * board side of the shared green led pins: strap resistors and leds.
 * assumes the hub drives a pin only while its output enable is high.
 */
`timescale 1ns/10ps
module hub_board_model (
   input  wire logic [3:0] ledOut,
   input  wire logic [3:0] ledOe,
   input  wire logic [1:0] disStrap,
   input  wire logic [1:0] fixStrap,
   output logic [3:0]      pinLevel
);
   // ****************************************************************
   // pin resolution
   // ****************************************************************
   // an undriven pin settles to its strap resistor level
   assign pinLevel = (ledOe & ledOut) | (~ledOe & {disStrap, fixStrap});
endmodule // hub_board_model

//--- tb/tb.sv
/*
 * self-checking bench of the hub strap / led / port power pin block.
 * assumes hub_pins_pkg and the board model are compiled first.
 */
`timescale 1ns/10ps
`define CHK(got, exp) begin cmpCount++; if ((got) !== (exp)) begin mismatches++; \
   $display("[ERR] %0t got %h exp %h", $time, (got), (exp)); end end
module tb;
   import hub_pins_pkg::*;
   // ****************************************************************
   // signals
   // ****************************************************************
   logic              clk, rst, upstream_vbus_sense, port_power_polarity_strap;
   logic              useDefaultConfig, upstreamPullupEnable, sp, dflt, ledEn;
   port_mask_t        port_power_enable, green_led_out, portPowerReq, greenLedReq;
   port_mask_t        portDisabled, portFixed;
   logic [3:0]        greenLedOe, greenLedIn, s_axi_wstrb;
   logic [2:0]        amber_led_out, amberLedReq;
   logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0]       s_axi_wdata, s_axi_rdata, rdData;
   logic [1:0]        s_axi_bresp, s_axi_rresp, resp, sd, sf, stDis, stFix;
   logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic              s_axi_rvalid, s_axi_rready;
   int                mismatches, cmpCount, k, seed;

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   hub_strap_led_port_power_pins i_dut (
      .clk(clk), .rst(rst), .upstream_vbus_sense(upstream_vbus_sense),
      .upstreamPullupEnable(upstreamPullupEnable),
      .port_power_polarity_strap(port_power_polarity_strap),
      .port_power_enable(port_power_enable), .green_led_out(green_led_out),
      .greenLedOe(greenLedOe), .greenLedIn(greenLedIn), .amber_led_out(amber_led_out),
      .useDefaultConfig(useDefaultConfig), .portPowerReq(portPowerReq),
      .greenLedReq(greenLedReq), .amberLedReq(amberLedReq),
      .portDisabled(portDisabled), .portFixed(portFixed),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
   );

   hub_board_model i_board (
      .ledOut(green_led_out[3:0]), .ledOe(greenLedOe), .disStrap(stDis),
      .fixStrap(stFix), .pinLevel(greenLedIn)
   );

   // ****************************************************************
   // expectations and bus tasks
   // ****************************************************************
   function automatic port_mask_t disMask(input logic [1:0] s);
      return {s != 2'h0, s[1], s == 2'h3, 4'h0};
   endfunction

   function automatic port_mask_t fixMask(input logic [1:0] s);
      return {4'h0, s == 2'h3, s[1], s != 2'h0};
   endfunction

   task finish_test;
      $display("compares %0d mismatches %0d", cmpCount, mismatches);
      if (mismatches == 0 && cmpCount > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task waited(input int n);
      if (n >= 50) begin
         mismatches++;
         $display("[ERR] %0t got %h exp %h", $time, n, 0);
         finish_test;
      end
   endtask

   task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid && n < 50);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      waited(n);
   endtask

   task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid && n < 50);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      waited(n);
   endtask

   // reset with straps on the pins; polarity pin flips mid-reset
   task run_reset;
      @(posedge clk);
      rst <= 1'b1;
      stDis <= sd;
      stFix <= sf;
      port_power_polarity_strap <= sp;
      repeat (5) @(posedge clk);
      #1 `CHK(port_power_enable, {NPORTS{~sp}})
      @(posedge clk);
      port_power_polarity_strap <= ~sp;
      repeat (4) @(posedge clk);
      #1 `CHK(port_power_enable, {NPORTS{sp}})
      @(posedge clk);
      port_power_polarity_strap <= sp;
      @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   task check_pins;
      port_mask_t pd;
      pd = dflt ? disMask(sd) : 7'h00;
      @(posedge clk);
      greenLedReq <= 7'($urandom);
      amberLedReq <= 3'($urandom);
      portPowerReq <= 7'($urandom);
      upstream_vbus_sense <= 1'($urandom);
      @(posedge clk);
      #1 `CHK(upstreamPullupEnable, upstream_vbus_sense)
      `CHK(green_led_out[6:4], ~greenLedReq[6:4])
      `CHK(amber_led_out, ~amberLedReq)
      `CHK(port_power_enable, (portPowerReq & ~pd) ^ {NPORTS{~sp}})
      `CHK(portDisabled, pd)
      `CHK(portFixed, dflt ? fixMask(sf) : 7'h00)
      if (dflt) begin
         `CHK(greenLedOe, 4'hf)
         `CHK(green_led_out[3:2], greenLedReq[3:2] ^ sd)
         `CHK(green_led_out[1:0], greenLedReq[1:0] ^ sf)
      end else if (ledEn) begin
         `CHK({greenLedOe[3:2], green_led_out[3:2]}, {2'h3, ~greenLedReq[3:2]})
         `CHK({greenLedOe[1:0], green_led_out[1:0]}, {2'h3, ~greenLedReq[1:0]})
      end else
         `CHK(greenLedOe, 4'h0)
   endtask

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      {rst, upstream_vbus_sense, port_power_polarity_strap, useDefaultConfig} = 4'h8;
      {portPowerReq, greenLedReq, amberLedReq, stDis, stFix} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      mismatches = 0;
      cmpCount = 0;
      seed = $urandom(32'h3079);
      repeat (10) @(posedge clk);
      for (k = 0; k < 4; k++) begin
         {sd, sf, sp, dflt, ledEn} = {2'(k), 2'(3 - k), 1'($urandom), 2'h2};
         useDefaultConfig <= 1'b1;
         run_reset;
         repeat (4) check_pins;
         // pins move after sampling; latched values must not
         @(posedge clk);
         stDis <= ~sd;
         stFix <= ~sf;
         port_power_polarity_strap <= ~sp;
         repeat (2) check_pins;
         axi_rd(REG_STATUS, rdData, resp);
         `CHK({resp, rdData}, {RESP_OKAY, 24'h0, 1'b1, upstream_vbus_sense, 1'b1, sp, sf, sd})
         axi_rd(REG_PORTS, rdData, resp);
         `CHK(rdData, {17'h0, fixMask(sf), 1'b0, disMask(sd)})
      end
      {sd, sf, sp, dflt, ledEn} = {4'h0, 1'($urandom), 2'h0};
      useDefaultConfig <= 1'b0;
      run_reset;
      stDis <= 2'h3;
      stFix <= 2'h3;
      check_pins;
      axi_rd(REG_CTRL, rdData, resp);
      `CHK({resp, rdData}, {RESP_OKAY, 31'h0, CTRL_LED_EN_RESET})
      axi_wr(REG_CTRL, 32'h1, resp);
      `CHK(resp, RESP_OKAY)
      ledEn = 1'b1;
      repeat (3) check_pins;
      axi_rd(REG_CTRL, rdData, resp);
      `CHK(rdData, 32'h1)
      axi_wr(REG_STATUS, 32'hff, resp);
      `CHK(resp, RESP_SLVERR)
      axi_rd(8'hfc, rdData, resp);
      `CHK({resp, rdData}, {RESP_SLVERR, 32'h0})
      check_pins;
      finish_test;
   end
endmodule // tb
